// *** src/ssu_pkg.sv ***
/*
 * Shared constants and types of the second serial port: register offsets,
 * reset values, control field positions, bit timing counts and state types.
 * Assumes an 8-bit special-function-register bus on a single system clock.
 */
package ssu_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_BUFFER = 8'h9c;
    localparam logic [7:0] ADDR_BAUD_LOW    = 8'h9d;
    localparam logic [7:0] ADDR_BAUD_HIGH   = 8'h9e;
    localparam logic [7:0] ADDR_CONTROL     = 8'h9f;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DATA_BUFFER  = 8'h00;
    localparam logic [7:0] RST_BAUD_LOW     = 8'h00;
    localparam logic [7:0] RST_BAUD_HIGH    = 8'h03;
    localparam logic [7:0] RST_CONTROL      = 8'h00;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int unsigned POS_MODE   = 7;
    localparam int unsigned POS_SPARE  = 6;
    localparam int unsigned POS_MPROC  = 5;
    localparam int unsigned POS_RXEN   = 4;
    localparam int unsigned POS_TB8    = 3;
    localparam int unsigned POS_RB8    = 2;
    localparam int unsigned POS_TI     = 1;
    localparam int unsigned POS_RI     = 0;

    // ------------------------------------------------------------------
    // Bit timing, in ticks of the 32-times bit clock
    // ------------------------------------------------------------------
    localparam logic [4:0] TICK_MID    = 5'h0f;
    localparam logic [4:0] TICK_LAST   = 5'h1f;
    localparam logic [3:0] LAST_BIT_8  = 4'h7;
    localparam logic [3:0] LAST_BIT_9  = 4'h8;
    localparam logic [9:0] BAUD_TOP    = 10'h3ff;

    // ------------------------------------------------------------------
    // Shifter states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSU_IDLE,
        SSU_START,
        SSU_DATA,
        SSU_STOP
    } ssu_state_t;

endpackage

// *** src/ssu_baud_if.sv ***
/*
 * Carrier between the serial port core and its baud tick generator.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface ssu_baud_if;
    logic [9:0] divisor;
    logic       tick;

    modport gen  (input divisor, output tick);
    modport user (output divisor, input tick);
endinterface

`default_nettype wire

// *** src/ssu_baud_gen.sv ***
/*
 * Baud tick generator: one tick every (1024 - divisor) system clocks,
 * which is thirty-two ticks per serial bit.
 * Assumes the divisor comes from registers on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module ssu_baud_gen (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Tick carrier
    ssu_baud_if.gen   bus
);

    logic [9:0] count;

    // Count up from the divisor and reload at the top
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count    <= 10'h000;
            bus.tick <= 1'b0;
        end else if (count == ssu_pkg::BAUD_TOP) begin
            count    <= bus.divisor;
            bus.tick <= 1'b1;
        end else begin
            count    <= count + 10'h001;
            bus.tick <= 1'b0;
        end
    end

    AST_BAUD_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bus.tick && $stable(bus.divisor)) |-> (count == bus.divisor))
        else $error("Baud counter did not reload from divisor");

endmodule

`default_nettype wire

// *** src/ssu_uart.sv ***
/*
 * Second asynchronous serial port: register file on the special function
 * register bus, transmitter, double-buffered receiver, multiprocessor filter.
 * Assumes bus strobes are single-cycle and synchronous to clk_sys; the
 * receive pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Control bit 7 picks framing: 0 gives nine data bits, 1 gives eight.
// - Buffer address writes go to transmitter; reads return receive buffer.
// - Receive buffer keeps old byte while next frame shifts in.
// - Eight-bit mode sends start 0, eight data bits LSB first, stop 1.
// - Nine-bit mode sends start, nine data bits, ninth from transmit bit eight.
// - Reception starts by aligning bit timing to a falling receive edge.
// - At frame end buffer loads; bit eight gets stop or ninth bit.
// - Buffer and received bit eight stay unchanged during a reception.
// - Bit rate is clock over 32 times (1024 minus ten-bit divisor).
// - With filter enabled, receive flag rises only when received bit eight (ninth bit, or stop bit in eight-bit mode) is one.
// - Transmit flag sets at stop bit start and stays until software clears.
// - Receive flag sets mid stop bit and stays until software clears.
// - Reception enable field: 0 enables reception, 1 disables it.
// - Only two low baud-high bits count; resets are 03h and 00h.
module ssu_uart (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Special function register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output var  logic [7:0] sfr_rdata,
    // Serial pins
    input  wire logic       receive_data_pin,
    output var  logic       transmit_data_pin
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Address match for a given register offset
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction

    // Index of the last data bit for the latched frame width
    function automatic logic [3:0] last_bit(input logic nine);
        last_bit = nine ? ssu_pkg::LAST_BIT_9 : ssu_pkg::LAST_BIT_8;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ssu_baud_if         baud_bus ();

    logic [7:0]         serial1_baud_low;
    logic [7:0]         serial1_baud_high;
    logic [7:0]         rx_buffer;

    logic               frame_mode_select;
    logic               spare_bit;
    logic               multiproc_filter_enable;
    logic               receive_enable_field;
    logic               transmit_bit_eight;
    logic               received_bit_eight;
    logic               transmit_complete_flag;
    logic               receive_complete_flag;

    logic               wr_buffer;
    logic               wr_control;

    ssu_pkg::ssu_state_t tx_state;
    logic [4:0]         tx_phase;
    logic [3:0]         tx_bit;
    logic [8:0]         tx_shift;
    logic               tx_nine;
    logic               tx_enter_stop;

    ssu_pkg::ssu_state_t rx_state;
    logic [4:0]         rx_phase;
    logic [3:0]         rx_bit;
    logic [8:0]         rx_bits;
    logic               rx_nine;
    logic               rx_finish;
    logic               next_rb8;
    logic               rx_flag_ok;

    logic               rxd_meta;
    logic               rxd_sync;
    logic               rxd_prev;
    logic               rxd_fall;

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------

    // Divisor takes only the two low bits of the high register
    assign baud_bus.divisor = {serial1_baud_high[1:0], serial1_baud_low};

    ssu_baud_gen u_baud (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .bus     (baud_bus)
    );

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------

    // Write strobes per register
    assign wr_buffer  = sfr_wr && reg_hit(sfr_addr, ssu_pkg::ADDR_DATA_BUFFER);
    assign wr_control = sfr_wr && reg_hit(sfr_addr, ssu_pkg::ADDR_CONTROL);

    // Baud registers, held whole but only low bits of high used
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial1_baud_low  <= ssu_pkg::RST_BAUD_LOW;
            serial1_baud_high <= ssu_pkg::RST_BAUD_HIGH;
        end else begin
            if (sfr_wr && reg_hit(sfr_addr, ssu_pkg::ADDR_BAUD_LOW)) begin
                serial1_baud_low <= sfr_wdata;
            end
            if (sfr_wr && reg_hit(sfr_addr, ssu_pkg::ADDR_BAUD_HIGH)) begin
                serial1_baud_high <= sfr_wdata;
            end
        end
    end

    // Plain control fields written by software only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frame_mode_select       <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_MODE];
            spare_bit               <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_SPARE];
            multiproc_filter_enable <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_MPROC];
            receive_enable_field    <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_RXEN];
            transmit_bit_eight      <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_TB8];
        end else if (wr_control) begin
            frame_mode_select       <= sfr_wdata[ssu_pkg::POS_MODE];
            spare_bit               <= sfr_wdata[ssu_pkg::POS_SPARE];
            multiproc_filter_enable <= sfr_wdata[ssu_pkg::POS_MPROC];
            receive_enable_field    <= sfr_wdata[ssu_pkg::POS_RXEN];
            transmit_bit_eight      <= sfr_wdata[ssu_pkg::POS_TB8];
        end
    end

    // Hardware-set fields: the hardware event wins over a software write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            received_bit_eight     <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_RB8];
            transmit_complete_flag <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_TI];
            receive_complete_flag  <= ssu_pkg::RST_CONTROL[ssu_pkg::POS_RI];
        end else begin
            if (rx_finish) begin
                received_bit_eight <= next_rb8;
            end else if (wr_control) begin
                received_bit_eight <= sfr_wdata[ssu_pkg::POS_RB8];
            end
            if (tx_enter_stop) begin
                transmit_complete_flag <= 1'b1;
            end else if (wr_control) begin
                transmit_complete_flag <= sfr_wdata[ssu_pkg::POS_TI];
            end
            if (rx_finish && rx_flag_ok) begin
                receive_complete_flag <= 1'b1;
            end else if (wr_control) begin
                receive_complete_flag <= sfr_wdata[ssu_pkg::POS_RI];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------

    // Registered read data, zero for unmapped offsets
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ssu_pkg::ADDR_DATA_BUFFER: sfr_rdata <= rx_buffer;
                ssu_pkg::ADDR_BAUD_LOW:    sfr_rdata <= serial1_baud_low;
                ssu_pkg::ADDR_BAUD_HIGH:   sfr_rdata <= serial1_baud_high;
                ssu_pkg::ADDR_CONTROL: begin
                    sfr_rdata <= {frame_mode_select, spare_bit,
                                  multiproc_filter_enable, receive_enable_field,
                                  transmit_bit_eight, received_bit_eight,
                                  transmit_complete_flag, receive_complete_flag};
                end
                default:                   sfr_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------

    // Last data bit ends and the stop bit begins
    assign tx_enter_stop = (tx_state == ssu_pkg::SSU_DATA) && baud_bus.tick &&
                           (tx_phase == ssu_pkg::TICK_LAST) &&
                           (tx_bit == last_bit(tx_nine));

    // Frame shifter; a buffer write while busy is ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_state          <= ssu_pkg::SSU_IDLE;
            tx_phase          <= 5'h00;
            tx_bit            <= 4'h0;
            tx_shift          <= 9'h000;
            tx_nine           <= 1'b0;
            transmit_data_pin <= 1'b1;
        end else begin
            case (tx_state)
                ssu_pkg::SSU_IDLE: begin
                    if (wr_buffer) begin
                        tx_state          <= ssu_pkg::SSU_START;
                        tx_phase          <= 5'h00;
                        tx_shift          <= {transmit_bit_eight, sfr_wdata};
                        tx_nine           <= !frame_mode_select;
                        transmit_data_pin <= 1'b0;
                    end
                end
                ssu_pkg::SSU_START: begin
                    if (baud_bus.tick) begin
                        tx_phase <= tx_phase + 5'h01;
                        if (tx_phase == ssu_pkg::TICK_LAST) begin
                            tx_state          <= ssu_pkg::SSU_DATA;
                            tx_bit            <= 4'h0;
                            transmit_data_pin <= tx_shift[0];
                        end
                    end
                end
                ssu_pkg::SSU_DATA: begin
                    if (baud_bus.tick) begin
                        tx_phase <= tx_phase + 5'h01;
                        if (tx_phase == ssu_pkg::TICK_LAST) begin
                            if (tx_enter_stop) begin
                                tx_state          <= ssu_pkg::SSU_STOP;
                                transmit_data_pin <= 1'b1;
                            end else begin
                                tx_bit            <= tx_bit + 4'h1;
                                tx_shift          <= {1'b1, tx_shift[8:1]};
                                transmit_data_pin <= tx_shift[1];
                            end
                        end
                    end
                end
                ssu_pkg::SSU_STOP: begin
                    if (baud_bus.tick) begin
                        tx_phase <= tx_phase + 5'h01;
                        if (tx_phase == ssu_pkg::TICK_LAST) begin
                            tx_state <= ssu_pkg::SSU_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state          <= ssu_pkg::SSU_IDLE;
                    transmit_data_pin <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------

    // Two-stage synchroniser plus edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            rxd_prev <= 1'b1;
        end else begin
            rxd_meta <= receive_data_pin;
            rxd_sync <= rxd_meta;
            rxd_prev <= rxd_sync;
        end
    end

    // Falling edge, end of frame, received bit eight and filter decision
    assign rxd_fall   = rxd_prev && !rxd_sync;
    assign rx_finish  = (rx_state == ssu_pkg::SSU_STOP) && baud_bus.tick &&
                        (rx_phase == ssu_pkg::TICK_LAST);
    assign next_rb8   = rx_nine ? rx_bits[8] : rxd_sync;
    assign rx_flag_ok = !multiproc_filter_enable || next_rb8;

    // Frame sampler; phase is offset so samples land mid-bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= ssu_pkg::SSU_IDLE;
            rx_phase <= 5'h00;
            rx_bit   <= 4'h0;
            rx_bits  <= 9'h000;
            rx_nine  <= 1'b0;
        end else begin
            case (rx_state)
                ssu_pkg::SSU_IDLE: begin
                    if (rxd_fall && !receive_enable_field) begin
                        rx_state <= ssu_pkg::SSU_START;
                        rx_phase <= 5'h00;
                        rx_nine  <= !frame_mode_select;
                    end
                end
                ssu_pkg::SSU_START: begin
                    if (baud_bus.tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase == ssu_pkg::TICK_MID) begin
                            rx_phase <= 5'h00;
                            rx_bit   <= 4'h0;
                            if (rxd_sync) begin
                                rx_state <= ssu_pkg::SSU_IDLE;
                            end else begin
                                rx_state <= ssu_pkg::SSU_DATA;
                            end
                        end
                    end
                end
                ssu_pkg::SSU_DATA: begin
                    if (baud_bus.tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase == ssu_pkg::TICK_LAST) begin
                            rx_bits[rx_bit] <= rxd_sync;
                            if (rx_bit == last_bit(rx_nine)) begin
                                rx_state <= ssu_pkg::SSU_STOP;
                            end else begin
                                rx_bit <= rx_bit + 4'h1;
                            end
                        end
                    end
                end
                ssu_pkg::SSU_STOP: begin
                    if (baud_bus.tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase == ssu_pkg::TICK_LAST) begin
                            rx_state <= ssu_pkg::SSU_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state <= ssu_pkg::SSU_IDLE;
                end
            endcase
        end
    end

    // Receive buffer replaced only when a frame completes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer <= ssu_pkg::RST_DATA_BUFFER;
        end else if (rx_finish) begin
            rx_buffer <= rx_bits[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_TX_START: assert property (
        (wr_buffer && tx_state == ssu_pkg::SSU_IDLE) |=> !transmit_data_pin)
        else $error("Start bit not driven after buffer write");

    AST_TX_STOP_HIGH: assert property (
        (tx_state == ssu_pkg::SSU_STOP) |-> transmit_data_pin)
        else $error("Stop bit not high");

    AST_TI_AT_STOP: assert property (
        $rose(tx_state == ssu_pkg::SSU_STOP) |-> transmit_complete_flag)
        else $error("Transmit flag not set at stop bit");

    AST_TI_STICKY: assert property (
        (transmit_complete_flag && !wr_control) |=> transmit_complete_flag)
        else $error("Transmit flag dropped without software");

    AST_RI_STICKY: assert property (
        (receive_complete_flag && !wr_control) |=> receive_complete_flag)
        else $error("Receive flag dropped without software");

    AST_BUF_HOLD: assert property (
        !rx_finish |=> $stable(rx_buffer))
        else $error("Receive buffer changed during reception");

    AST_MP_FILTER: assert property (
        (rx_finish && multiproc_filter_enable && !next_rb8 &&
         !receive_complete_flag && !wr_control) |=> !receive_complete_flag)
        else $error("Filtered frame raised receive flag");

    AST_RX_DISABLED: assert property (
        (rx_state == ssu_pkg::SSU_IDLE && receive_enable_field)
        |=> (rx_state == ssu_pkg::SSU_IDLE))
        else $error("Reception started while disabled");

    AST_START_ABORT: assert property (
        (rx_state == ssu_pkg::SSU_START && baud_bus.tick &&
         rx_phase == ssu_pkg::TICK_MID && rxd_sync)
        |=> (rx_state == ssu_pkg::SSU_IDLE))
        else $error("False start bit not abandoned");

    AST_RB8_LOAD: assert property (
        rx_finish |=> (received_bit_eight == $past(next_rb8)))
        else $error("Received bit eight not loaded at frame end");

endmodule

`default_nettype wire

// *** verif/ssu_remote_node.sv ***
/* Remote serial node: drives frames onto the receive pin, captures frames
   from the transmit pin. Assumes one serial bit lasts 32 system clocks. */
`timescale 1ns/1ns
`default_nettype none
module ssu_remote_node (
    // Clock
    input  wire logic clk_sys,
    // Serial line
    input  wire logic tx_line,
    output var  logic rx_line
);
    // -----------------------------------------------------------------
    // Line tasks
    // -----------------------------------------------------------------
    initial rx_line = 1'b1;
    // Start 0, n data bits LSB first, ninth chosen by caller, stop 1
    task automatic send(input int n, input logic [8:0] d);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        f[n + 1] = 1'b1;
        for (int i = 0; i < n + 2; i++) begin
            rx_line = f[i];
            repeat (32) @(posedge clk_sys);
            #1;
        end
    endtask
    // Short low pulse that must not start a frame
    task automatic pulse(input int n);
        rx_line = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1 rx_line = 1'b1;
    endtask
    // Capture start, n data bits and stop at bit centres
    task automatic grab(input int n, output logic [10:0] v);
        v = '1;
        @(negedge tx_line);
        repeat (16) @(posedge clk_sys);
        for (int i = 0; i < n + 2; i++) begin
            v[i] = tx_line;
            if (i < n + 1) repeat (32) @(posedge clk_sys);
        end
        // Step off the edge so the caller drives the bus clear of it
        #1;
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
/* Self-checking bench of the second serial port: register tasks plus
   the remote node model. Assumes divisor 3ffh, so one tick per clock. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // -----------------------------------------------------------------
    // Signals, clock, instances
    // -----------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        rst_n, sfr_wr, sfr_rd, rxd, txd;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    logic [10:0] v;
    int          fail_count = 0;
    int          check_count = 0;
    always #2 clk_sys = ~clk_sys;
    ssu_uart dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .receive_data_pin(rxd), .transmit_data_pin(txd));
    ssu_remote_node node (.clk_sys(clk_sys), .tx_line(txd), .rx_line(rxd));
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #1 sfr_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // Read data lands the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #1 sfr_rd = 1'b0;
        chk({3'h0, sfr_rdata}, {3'h0, exp});
        @(posedge clk_sys);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Watchdog counts a mismatch and closes the run
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
    // Test sequence
    initial begin
        rst_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
        idle(4);
        rst_n = 1'b1;
        rd(8'h9c, 8'h00); rd(8'h9d, 8'h00); rd(8'h9e, 8'h03);
        rd(8'h9f, 8'h00); rd(8'h9b, 8'h00);
        wr(8'h9d, 8'hff); wr(8'h9e, 8'hff); rd(8'h9e, 8'hff); rd(8'h9d, 8'hff);
        $display("test registers done");
        idle(1100);
        wr(8'h9f, 8'h80);
        fork node.grab(8, v); wr(8'h9c, 8'ha5); join
        chk(v, {2'b11, 8'ha5, 1'b0});
        rd(8'h9f, 8'h82);
        idle(24);
        wr(8'h9f, 8'h08);
        fork node.grab(9, v); wr(8'h9c, 8'h3c); join
        chk(v, {1'b1, 9'h13c, 1'b0});
        rd(8'h9f, 8'h0a);
        idle(24);
        $display("test transmit done");
        wr(8'h9f, 8'h80); node.send(8, 9'h15a); idle(4);
        rd(8'h9c, 8'h5a); rd(8'h9f, 8'h85);
        fork
            node.send(8, 9'h1c3);
            begin
                idle(150);
                rd(8'h9c, 8'h5a);
                rd(8'h9f, 8'h85);
            end
        join
        idle(4);
        rd(8'h9c, 8'hc3);
        wr(8'h9f, 8'h20); node.send(9, 9'h1a7); idle(4);
        rd(8'h9c, 8'ha7); rd(8'h9f, 8'h25);
        wr(8'h9f, 8'h20); node.send(9, 9'h042); idle(4);
        rd(8'h9c, 8'h42); rd(8'h9f, 8'h20);
        wr(8'h9f, 8'h00); node.pulse(6); idle(400);
        rd(8'h9f, 8'h00);
        wr(8'h9f, 8'h90); node.send(8, 9'h199); idle(4);
        rd(8'h9c, 8'h42); rd(8'h9f, 8'h90);
        $display("test receive done");
        test_done();
    end
endmodule
`default_nettype wire
